// File: logic/mctr_top.v
// Purpose: Result store, fault flags, block reads and two overtemperature alerts for nine channels.
// Assumes: APB slave with zero wait states; front end delivers one frame per conversion.
// Notes: Channel 0 is local, channels 1 to 8 are remote diodes.
//
// What this block does
// - thirteen-bit results, one sixteenth degree each
// - negative temperatures in two's complement
// - word spans minus 256 to 255.9375
// - result left-justified, three low zeros
// - high byte two degrees per count
// - shorted diode reads most negative code
// - open comparator watched, sets fault flag
// - one hysteresis shared by both alerts
// - alerts follow programmed limits
// - strap pin picks one of four addresses
// - one local plus eight remote results
// - mirror at 80h-88h, block reads there only
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mctr_regs.vh"

module mctr_top #(
  parameter NCHAN = 9,
  parameter RES_BITS = 13
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Front-end conversion link
  input wire fe_clk,
  input wire fe_frame,
  input wire fe_data,
  input wire fe_open,
  input wire fe_short,
  input wire [3:0] fe_chan,
  // Address strap
  input wire [1:0] addr_sel,
  // Alerts and interrupt
  output reg primary_overtemp_alert_n,
  output reg secondary_overtemp_alert,
  output reg irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg [15:0] result [0:NCHAN-1];
  reg [15:0] limit1 [0:NCHAN-1];
  reg [15:0] limit2 [0:NCHAN-1];
  reg [15:0] hyst;
  reg [7:0] remote_open_fault_flag;
  reg [`MCTR_STAT_W-1:0] stat;
  reg [`MCTR_STAT_W-1:0] mask;
  reg [`MCTR_STAT_W-1:0] stat_set;
  reg [7:0] bptr;
  reg [6:0] bus_addr;
  reg [1:0] sel_a;
  reg [1:0] sel_b;
  reg [1:0] strap_cnt;
  reg prim_d;
  reg sec_d;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  wire [NCHAN-1:0] prim_vec;
  wire [NCHAN-1:0] sec_vec;
  wire prim_any = |prim_vec;
  wire sec_any = |sec_vec;
  wire conv_done;
  wire [3:0] conv_chan;
  wire [15:0] conv_word;
  wire conv_open;
  wire conv_short;
  wire [3:0] rch = conv_chan - 4'h1;
  wire conv_remote = (conv_chan != `MCTR_LOCAL_CHAN) && (conv_chan <= `MCTR_LAST_CHAN);
  wire conv_valid = conv_chan <= `MCTR_LAST_CHAN;
  wire [9:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_acc = access & pwrite & ~pslverr;
  wire rd_acc = access & ~pwrite & ~pslverr;
  integer i;
  integer j;

  // Values between the pointer range limits, both limits included, are the only legal block pointers.
  function in_range;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function [31:0] word32;
    input [15:0] w;
    begin
      word32 = {16'h0000, w};
    end
  endfunction

  assign pready = 1'b1;

  // --------------------------------------------------------------------------
  // Conversion link
  // --------------------------------------------------------------------------
  mctr_link #(
    .RES_BITS(RES_BITS)
  ) u_link (
    .pclk(pclk),
    .presetn(presetn),
    .fe_clk(fe_clk),
    .fe_frame(fe_frame),
    .fe_data(fe_data),
    .fe_open(fe_open),
    .fe_short(fe_short),
    .fe_chan(fe_chan),
    .conv_done(conv_done),
    .conv_chan(conv_chan),
    .conv_word(conv_word),
    .conv_open(conv_open),
    .conv_short(conv_short)
  );

  // --------------------------------------------------------------------------
  // Result store and fault flags
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NCHAN; i = i + 1) begin
        result[i] <= `MCTR_RES_RST;
      end
      remote_open_fault_flag <= 8'h00;
    end else if (conv_done && conv_valid) begin
      result[conv_chan] <= conv_word;
      if (conv_remote && conv_short) begin
        result[conv_chan] <= `MCTR_SHORT_CODE;
      end
      if (conv_remote) begin
        remote_open_fault_flag[rch[2:0]] <= conv_open;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Alert comparators
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCHAN; g = g + 1) begin : gen_alert
      mctr_alert u_prim (
        .pclk(pclk),
        .presetn(presetn),
        .result(result[g]),
        .limit(limit1[g]),
        .hyst(hyst),
        .alert(prim_vec[g])
      );
      mctr_alert u_sec (
        .pclk(pclk),
        .presetn(presetn),
        .result(result[g]),
        .limit(limit2[g]),
        .hyst(hyst),
        .alert(sec_vec[g])
      );
    end
  endgenerate

  // Registering the pins costs one cycle but keeps glitches of the channel OR off the board.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_overtemp_alert_n <= 1'b1;
      secondary_overtemp_alert <= 1'b0;
      prim_d <= 1'b0;
      sec_d <= 1'b0;
    end else begin
      primary_overtemp_alert_n <= ~prim_any;
      secondary_overtemp_alert <= sec_any;
      prim_d <= prim_any;
      sec_d <= sec_any;
    end
  end

  // --------------------------------------------------------------------------
  // Address strap
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a <= 2'b00;
      sel_b <= 2'b00;
      strap_cnt <= 2'b00;
      bus_addr <= `MCTR_BASE_BUS_ADDR;
    end else begin
      sel_a <= addr_sel;
      sel_b <= sel_a;
      // The strap is taken once the second stage holds a pin sample, never the reset zeros.
      if (strap_cnt != 2'b11) begin
        strap_cnt <= strap_cnt + 2'b01;
      end
      if (strap_cnt == 2'b10) begin
        bus_addr <= `MCTR_BASE_BUS_ADDR | {5'b00000, sel_b};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    wr_ok = 1'b0;
    if (in_range(idx, `MCTR_IDX_RES_FIRST, `MCTR_IDX_RES_LAST)) begin
      rd_data = word32(result[idx[3:0]]);
    end else if (in_range(idx, `MCTR_IDX_MIR_FIRST, `MCTR_IDX_MIR_LAST)) begin
      rd_data = word32(result[idx[3:0]]);
    end else if (in_range(idx, `MCTR_IDX_LIM1_FIRST, `MCTR_IDX_LIM1_LAST)) begin
      rd_data = word32(limit1[idx[3:0]]);
      wr_ok = 1'b1;
    end else if (in_range(idx, `MCTR_IDX_LIM2_FIRST, `MCTR_IDX_LIM2_LAST)) begin
      rd_data = word32(limit2[idx[3:0]]);
      wr_ok = 1'b1;
    end else begin
      case (idx)
        `MCTR_IDX_HYST: begin
          rd_data = word32(hyst);
          wr_ok = 1'b1;
        end
        `MCTR_IDX_FAULT: begin
          rd_data = {24'h00_0000, remote_open_fault_flag};
        end
        `MCTR_IDX_STAT: begin
          rd_data = {22'h00_0000, stat};
          wr_ok = 1'b1;
        end
        `MCTR_IDX_MASK: begin
          rd_data = {22'h00_0000, mask};
          wr_ok = 1'b1;
        end
        `MCTR_IDX_ALERT: begin
          rd_data = {7'h00, sec_vec, 7'h00, prim_vec};
        end
        `MCTR_IDX_BUSADDR: begin
          rd_data = {25'h000_0000, bus_addr};
        end
        `MCTR_IDX_BPTR: begin
          rd_data = {24'h00_0000, bptr};
          wr_ok = in_range({2'b00, pwdata[7:0]}, {2'b00, `MCTR_BPTR_FIRST}, {2'b00, `MCTR_BPTR_LAST}) &&
                  (pwdata[31:8] == 24'h00_0000);
        end
        `MCTR_IDX_BDATA: begin
          rd_data = word32(result[bptr[3:0]]);
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= pwrite ? ~wr_ok : ~rd_ok;
    end else if (access) begin
      pslverr <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < NCHAN; j = j + 1) begin
        limit1[j] <= `MCTR_LIMIT_RST;
        limit2[j] <= `MCTR_LIMIT_RST;
      end
      hyst <= `MCTR_HYST_RST;
      mask <= {`MCTR_STAT_W{1'b0}};
      bptr <= `MCTR_BPTR_FIRST;
    end else begin
      if (wr_acc) begin
        if (in_range(idx, `MCTR_IDX_LIM1_FIRST, `MCTR_IDX_LIM1_LAST)) begin
          limit1[idx[3:0]] <= {pwdata[15:3], `MCTR_LOW_ZERO};
        end
        if (in_range(idx, `MCTR_IDX_LIM2_FIRST, `MCTR_IDX_LIM2_LAST)) begin
          limit2[idx[3:0]] <= {pwdata[15:3], `MCTR_LOW_ZERO};
        end
        if (idx == `MCTR_IDX_HYST) begin
          hyst <= pwdata[15:0] & `MCTR_HYST_MASK;
        end
        if (idx == `MCTR_IDX_MASK) begin
          mask <= pwdata[`MCTR_STAT_W-1:0];
        end
        if (idx == `MCTR_IDX_BPTR) begin
          bptr <= pwdata[7:0];
        end
      end
      if (rd_acc && (idx == `MCTR_IDX_BDATA)) begin
        bptr <= (bptr == `MCTR_BPTR_LAST) ? `MCTR_BPTR_FIRST : bptr + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  always @* begin
    stat_set = {`MCTR_STAT_W{1'b0}};
    if (conv_done && conv_remote && conv_open) begin
      stat_set[`MCTR_STAT_OPEN_LSB + rch[2:0]] = 1'b1;
    end
    stat_set[`MCTR_STAT_PRIM_BIT] = prim_any & ~prim_d;
    stat_set[`MCTR_STAT_SEC_BIT] = sec_any & ~sec_d;
  end

  // A new event in the cycle of a write-one-to-clear keeps its bit set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= {`MCTR_STAT_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr_acc && (idx == `MCTR_IDX_STAT)) begin
        stat <= (stat & ~pwdata[`MCTR_STAT_W-1:0]) | stat_set;
      end else begin
        stat <= stat | stat_set;
      end
      irq <= |(stat & mask);
    end
  end

endmodule // mctr_top
`default_nettype wire

// File: shared/mctr_regs.vh
// Purpose: Register indices, field values and reset values of the temperature result and alert block.
// Assumes: Byte address on APB is four times the register index.
// Notes: Definitions only.
`ifndef MCTR_REGS_VH
`define MCTR_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define MCTR_IDX_RES_FIRST 10'h000
`define MCTR_IDX_RES_LAST 10'h008
`define MCTR_IDX_HYST 10'h020
`define MCTR_IDX_FAULT 10'h021
`define MCTR_IDX_STAT 10'h022
`define MCTR_IDX_MASK 10'h023
`define MCTR_IDX_ALERT 10'h024
`define MCTR_IDX_BUSADDR 10'h025
`define MCTR_IDX_BPTR 10'h026
`define MCTR_IDX_BDATA 10'h027
`define MCTR_IDX_LIM1_FIRST 10'h030
`define MCTR_IDX_LIM1_LAST 10'h038
`define MCTR_IDX_LIM2_FIRST 10'h040
`define MCTR_IDX_LIM2_LAST 10'h048
`define MCTR_IDX_MIR_FIRST 10'h080
`define MCTR_IDX_MIR_LAST 10'h088

// ----------------------------------------------------------------------------
// Block read pointer range
// ----------------------------------------------------------------------------
`define MCTR_BPTR_FIRST 8'h80
`define MCTR_BPTR_LAST 8'h88

// ----------------------------------------------------------------------------
// Data format and reset values
// ----------------------------------------------------------------------------
`define MCTR_SHORT_CODE 16'h8000
`define MCTR_LOW_ZERO 3'b000
`define MCTR_RES_RST 16'h0000
`define MCTR_LIMIT_RST 16'h7FF8
`define MCTR_HYST_RST 16'h0500
`define MCTR_HYST_MASK 16'h7FF8
`define MCTR_STAT_OPEN_LSB 0
`define MCTR_STAT_PRIM_BIT 8
`define MCTR_STAT_SEC_BIT 9
`define MCTR_STAT_W 10
`define MCTR_SEC_ALERT_LSB 16
`define MCTR_BASE_BUS_ADDR 7'h48
`define MCTR_LOCAL_CHAN 4'h0
`define MCTR_LAST_CHAN 4'h8

`endif

// File: logic/mctr_link.v
// Purpose: Samples the front-end conversion link on pclk and delivers one finished result per frame.
// Assumes: Channel number is stable for the whole frame; data bits shift in on link clock rising edges.
// Notes: Link clock is sampled, not used as a clock.
`timescale 1ns/100ps
`default_nettype none
`include "mctr_regs.vh"

module mctr_link #(
  parameter RES_BITS = 13
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Front-end link pins
  input wire fe_clk,
  input wire fe_frame,
  input wire fe_data,
  input wire fe_open,
  input wire fe_short,
  input wire [3:0] fe_chan,
  // Finished conversion
  output reg conv_done,
  output reg [3:0] conv_chan,
  output reg [15:0] conv_word,
  output reg conv_open,
  output reg conv_short
);

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  // The channel bits cross as a bus; this is safe only because they never move inside a frame.
  reg [8:0] sync_a;
  reg [8:0] sync_b;
  reg clk_d;
  reg frame_d;
  reg [RES_BITS-1:0] shift;
  reg open_seen;
  reg short_seen;
  wire s_clk = sync_b[8];
  wire s_frame = sync_b[7];
  wire s_data = sync_b[6];
  wire s_open = sync_b[5];
  wire s_short = sync_b[4];
  wire [3:0] s_chan = sync_b[3:0];
  wire clk_rise = s_clk & ~clk_d;
  wire frame_rise = s_frame & ~frame_d;
  wire frame_fall = ~s_frame & frame_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end else begin
      sync_a <= {fe_clk, fe_frame, fe_data, fe_open, fe_short, fe_chan};
      sync_b <= sync_a;
    end
  end

  // --------------------------------------------------------------------------
  // Frame capture
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d <= 1'b0;
      frame_d <= 1'b0;
      shift <= {RES_BITS{1'b0}};
      open_seen <= 1'b0;
      short_seen <= 1'b0;
      conv_done <= 1'b0;
      conv_chan <= 4'h0;
      conv_word <= `MCTR_RES_RST;
      conv_open <= 1'b0;
      conv_short <= 1'b0;
    end else begin
      clk_d <= s_clk;
      frame_d <= s_frame;
      conv_done <= 1'b0;
      if (frame_rise) begin
        open_seen <= s_open;
        short_seen <= s_short;
      end else if (s_frame) begin
        open_seen <= open_seen | s_open;
        short_seen <= short_seen | s_short;
      end
      if (s_frame && clk_rise) begin
        shift <= {shift[RES_BITS-2:0], s_data};
      end
      if (frame_fall) begin
        conv_done <= 1'b1;
        conv_chan <= s_chan;
        conv_word <= {shift, `MCTR_LOW_ZERO};
        conv_open <= open_seen;
        conv_short <= short_seen;
      end
    end
  end

endmodule // mctr_link
`default_nettype wire

// File: logic/mctr_alert.v
// Purpose: One overtemperature comparator with hysteresis for one channel and one limit.
// Assumes: Result, limit and hysteresis share the left-justified two's-complement word format.
// Notes: Hysteresis is never negative.
`timescale 1ns/100ps
`default_nettype none

module mctr_alert (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Compare operands
  input wire [15:0] result,
  input wire [15:0] limit,
  input wire [15:0] hyst,
  // Alert state
  output reg alert
);

  wire signed [16:0] res_s = {result[15], result};
  wire signed [16:0] lim_s = {limit[15], limit};
  wire signed [16:0] rel_s = lim_s - $signed({1'b0, hyst});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert <= 1'b0;
    end else if (!alert && (res_s > lim_s)) begin
      alert <= 1'b1;
    end else if (alert && (res_s < rel_s)) begin
      alert <= 1'b0;
    end
  end

endmodule // mctr_alert
`default_nettype wire

// File: tb/mctr_props.sv
// Purpose: Port-level checks of the temperature result and alert block.
// Assumes: Zero-wait APB slave; byte address is index times four.
// Notes: Bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module mctr_props #(
  parameter NCHAN = 9,
  parameter RES_BITS = 13
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  // Strap and outputs
  input wire [1:0] addr_sel,
  input wire primary_overtemp_alert_n,
  input wire secondary_overtemp_alert,
  input wire irq
);
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  wire [9:0] idx = paddr[11:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  result_format_a: assert property (
    rd && idx <= 10'h008 |-> !pslverr && prdata[31:16] == 16'h0000 && prdata[2:0] == 3'b000)
    else $error("Result word badly formatted.");
  mirror_read_a: assert property (
    rd && idx >= 10'h080 && idx <= 10'h088 |-> !pslverr && prdata[2:0] == 3'b000)
    else $error("Mirror read refused or badly formatted.");
  result_readonly_a: assert property (
    wr && idx <= 10'h008 |-> pslverr)
    else $error("Write to a result was accepted.");
  block_pointer_a: assert property (
    wr && idx == 10'h026 && (pwdata < 32'h0000_0080 || pwdata > 32'h0000_0088) |-> pslverr)
    else $error("Block pointer outside the mirror was accepted.");
  unmapped_read_a: assert property (
    rd && idx >= 10'h009 && idx <= 10'h01F |-> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped read not refused.");
  bus_address_a: assert property (
    rd && idx == 10'h025 |-> prdata == {30'h0000_0012, addr_sel})
    else $error("Bus address does not follow the strap.");
  hyst_store_a: assert property (
    rd && idx == 10'h020 |-> (prdata & 32'hFFFF_8007) == 32'h0000_0000)
    else $error("Hysteresis holds bits outside its field.");
  limit_store_a: assert property (
    rd && ((idx >= 10'h030 && idx <= 10'h038) || (idx >= 10'h040 && idx <= 10'h048))
    |-> prdata[2:0] == 3'b000 && prdata[31:16] == 16'h0000)
    else $error("Limit holds bits outside its field.");
  mask_off_a: assert property (
    wr && idx == 10'h023 && pwdata[9:0] == 10'h000 |-> ##2 !irq)
    else $error("Interrupt stays high with every event masked.");
  reset_idle_a: assert property (
    $rose(presetn) |-> primary_overtemp_alert_n && !secondary_overtemp_alert && !irq)
    else $error("Outputs not idle after reset.");
  cover property (rd && idx <= 10'h008 && prdata != 32'h0000_0000);
  cover property ($rose(irq));
  cover property ($fell(primary_overtemp_alert_n));
endmodule // mctr_props
bind mctr_top mctr_props #(.NCHAN(NCHAN), .RES_BITS(RES_BITS)) i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .addr_sel(addr_sel), .primary_overtemp_alert_n(primary_overtemp_alert_n),
  .secondary_overtemp_alert(secondary_overtemp_alert), .irq(irq));
`default_nettype wire

// File: tb/mctr_fe_model.sv
// Purpose: Behavioural front end that sends one conversion frame per call.
// Assumes: Link clock of 80 ns that runs only inside a frame.
// Notes: Data line has no pull, so it shows the inverse level between frames.
`timescale 1ns/100ps
`default_nettype none
module mctr_fe_model (
  // Link pins
  output logic fe_clk,
  output logic fe_frame,
  output logic fe_data,
  output logic fe_open,
  output logic fe_short,
  output logic [3:0] fe_chan
);
  initial begin
    fe_clk = 1'b0;
    fe_frame = 1'b0;
    fe_data = 1'b0;
    fe_open = 1'b0;
    fe_short = 1'b0;
    fe_chan = 4'hF;
  end
  task automatic conv(input logic [3:0] ch, input logic [12:0] code, input logic op, input logic sh,
                      input int gap);
    int i;
    // Keep every pin change up to the end of the frame off the pclk sampling edge.
    #1;
    fe_chan = ch;
    fe_frame = 1'b1;
    fe_short = sh; // short
    for (i = 12; i >= 0; i--) begin
      fe_data = code[i];
      fe_open = op && i == 6;
      #40 fe_clk = 1'b1;
      #40 fe_clk = 1'b0;
    end
    #40 fe_frame = 1'b0;
    fe_short = 1'b0;
    fe_data = ~fe_data;
    #(gap) fe_chan = 4'hF;
  endtask
endmodule // mctr_fe_model
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench of the temperature result and alert block.
// Assumes: Zero-wait APB; results land a few pclk after a frame ends.
// Notes: A monitor compares each APB answer with the oldest queued note.
`timescale 1ns/100ps
`default_nettype none
`include "mctr_regs.vh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] addr_sel;
  wire pready, pslverr, fe_clk, fe_frame, fe_data, fe_open, fe_short, alert_n, alert2, irq;
  wire [31:0] prdata;
  wire [3:0] fe_chan;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 99;
  logic [33:0] exp_q[$];
  logic [12:0] codes [0:8];
  logic [14:0] tab [0:6] = '{{13'h01E0, 2'b00}, {13'h03C0, 2'b01}, {13'h0310, 2'b01}, {13'h02F0, 2'b00},
                             {13'h0180, 2'b00}, {13'h0160, 2'b10}, {13'h0190, 2'b10}};
  always #2.5 pclk = ~pclk;
  mctr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fe_clk(fe_clk),
    .fe_frame(fe_frame), .fe_data(fe_data), .fe_open(fe_open), .fe_short(fe_short), .fe_chan(fe_chan),
    .addr_sel(addr_sel), .primary_overtemp_alert_n(alert_n), .secondary_overtemp_alert(alert2), .irq(irq));
  mctr_fe_model i_fe (.fe_clk(fe_clk), .fe_frame(fe_frame), .fe_data(fe_data), .fe_open(fe_open),
    .fe_short(fe_short), .fe_chan(fe_chan));
  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Psel stays up at the end so that transfers may follow back to back.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e,
                     input logic [31:0] x);
    int n;
    n = 0;
    exp_q.push_back({e, !wr, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 100) begin
      miscompares++;
      $display("CHECK FAILED %0t no ready from slave", $time);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, 1'b0, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic frame(input logic [3:0] ch, input logic [12:0] c, input logic op, input logic sh);
    idle(1);
    i_fe.conv(ch, c, op, sh, 100 + ($random(seed) & 255));
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
      check(32'(pslverr), 32'(e[33]), "slave error");
      if (e[32]) check(prdata, e[31:0], "read data");
    end
  end
  initial begin
    #200_000;
    miscompares++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    conclude();
  end
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    int i;
    addr_sel <= 2'($random(seed));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i <= 8; i++) begin
      rd(12'(4 * i), 32'h0000_0000);
      rd(12'(12'h0C0 + 4 * i), {16'h0000, `MCTR_LIMIT_RST});
      rd(12'(12'h100 + 4 * i), {16'h0000, `MCTR_LIMIT_RST});
    end
    rd(12'h080, {16'h0000, `MCTR_HYST_RST});
    rd(12'h094, 32'h0000_0048 | 32'(addr_sel));
    apb(1'b0, 12'h040, 32'h0000_0000, 1'b1, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0000_1234, 1'b1, 32'h0000_0000);
    apb(1'b1, 12'h098, 32'h0000_0089, 1'b1, 32'h0000_0000);
    apb(1'b1, 12'h098, 32'h0000_007F, 1'b1, 32'h0000_0000);
    rd(12'h098, 32'h0000_0080);
    codes[0] = 13'h1000;
    codes[1] = 13'h0FFF;
    codes[2] = 13'h1FFF;
    codes[3] = 13'h0010;
    codes[4] = 13'h0001;
    for (i = 5; i <= 8; i++) codes[i] = 13'($random(seed));
    for (i = 0; i <= 8; i++) frame(4'(i), codes[i], 1'b0, 1'b0);
    for (i = 0; i <= 8; i++) begin
      rd(12'(4 * i), {16'h0000, codes[i], 3'b000});
      rd(12'(12'h200 + 4 * i), {16'h0000, codes[i], 3'b000});
    end
    check(32'(alert_n), 32'h0000_0001, "alert at limit");
    wr(12'h098, 32'h0000_0087);
    rd(12'h09C, {16'h0000, codes[7], 3'b000});
    rd(12'h09C, {16'h0000, codes[8], 3'b000});
    rd(12'h09C, {16'h0000, codes[0], 3'b000});
    rd(12'h098, 32'h0000_0081);
    wr(12'h08C, 32'h0000_0002);
    frame(4'h2, 13'h0123, 1'b1, 1'b0);
    check(32'(irq), 32'h0000_0001, "irq on open");
    rd(12'h084, 32'h0000_0002);
    frame(4'h3, 13'h0456, 1'b0, 1'b1);
    rd(12'h00C, {16'h0000, `MCTR_SHORT_CODE});
    frame(4'h0, 13'h0456, 1'b1, 1'b1);
    rd(12'h000, 32'h0000_22B0);
    frame(4'h2, 13'h0123, 1'b0, 1'b0);
    rd(12'h084, 32'h0000_0000);
    rd(12'h088, 32'h0000_0002);
    wr(12'h08C, 32'h0000_0000);
    idle(3);
    check(32'(irq), 32'h0000_0000, "irq masked");
    wr(12'h08C, 32'h0000_0002);
    idle(3);
    check(32'(irq), 32'h0000_0001, "irq unmasked");
    wr(12'h088, 32'h0000_0002);
    idle(3);
    check(32'(irq), 32'h0000_0000, "irq cleared");
    wr(12'h080, 32'h0000_0107);
    rd(12'h080, 32'h0000_0100);
    wr(12'h0C4, 32'h0000_0C80);
    wr(12'h104, 32'h0000_1900);
    for (i = 0; i < 7; i++) begin
      frame(4'h1, tab[i][14:2], 1'b0, 1'b0);
      check(32'(alert_n), 32'(tab[i][1]), "primary alert");
      check(32'(alert2), 32'(tab[i][0]), "secondary alert");
    end
    rd(12'h088, 32'h0000_0300);
    idle(2);
    check(32'(exp_q.size()), 32'h0000_0000, "answers missing");
    conclude();
  end
endmodule // tb
`default_nettype wire
